// File: rtl/spdif_rx_flags_pkg.sv
// Shared constants for the receiver fault flag block.
// Assumes an 8-bit register port with 7-bit register addresses.
package spdif_rx_flags_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register addresses on the control port
  localparam logic [6:0] FAULT_FLAGS_ADDR = 7'h18;
  localparam logic [6:0] FAULT_ENABLE_ADDR = 7'h19;
  localparam logic [6:0] IRQ_STATUS_ADDR = 7'h1C;

  ////////////////////////////////////////////////////////////////////////////
  // Bit positions in the fault flag and enable registers
  localparam int VALID_BIT = 7;
  localparam int EMPHASIS_BIT = 6;
  localparam int NONAUDIO_BIT = 5;
  localparam int PREAMBLE_BIT = 4;
  localparam int CHECK_FAIL_BIT = 3;
  localparam int ABSENT_BIT = 2;
  localparam int CODING_BIT = 1;
  localparam int LOCK_BIT = 0;
  localparam int FLAG_COUNT = 8;

  // Summary bit position in the interrupt status register
  localparam int SUMMARY_BIT = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Flag kinds: a set bit marks a sticky, read-to-clear flag
  localparam logic [7:0] STICKY_MAP = 8'h0A;

  ////////////////////////////////////////////////////////////////////////////
  // Values after reset
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam logic [7:0] RDATA_RESET = 8'h00;
  localparam logic       SUMMARY_RESET = 1'b0;

  // Width of the nonaudio type code from the receiver
  localparam int NONAUDIO_TYPE_W = 4;
  localparam logic [NONAUDIO_TYPE_W-1:0] TYPE_RESET = 4'h0;

  // Number of flip-flops in each level synchroniser
  localparam int SYNC_STAGES = 2;

endpackage

// File: rtl/level_sync.sv
// Two-stage synchroniser for slow level signals.
// Assumes the inputs are levels that stay put for several clocks.
module level_sync
  import spdif_rx_flags_pkg::*;
#(
  parameter int WIDTH = 2
) (
  // Clock and reset
  input  wire logic             sys_clk_i,
  input  wire logic             rst_i,
  // Asynchronous levels in, synchronised levels out
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] stable_q;

  ////////////////////////////////////////////////////////////////////////////
  // First stage feeds only the second stage
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      meta_q   <= '0;
      stable_q <= '0;
    end else begin
      meta_q   <= async_i;
      stable_q <= meta_q;
    end
  end

  assign sync_o = stable_q;

endmodule

// File: rtl/fault_flag_cell.sv
// One fault flag with its pending-event bit.
// Assumes set_i and retrig_i are one-cycle pulses on sys_clk_i.
module fault_flag_cell
  import spdif_rx_flags_pkg::*;
#(
  parameter logic STICKY = 1'b0
) (
  // Clock and reset
  input  wire logic sys_clk_i,
  input  wire logic rst_i,
  // Flag sources
  input  wire logic level_i,
  input  wire logic set_i,
  input  wire logic retrig_i,
  // Read of the flag register
  input  wire logic clear_i,
  // Flag value and pending event
  output logic      flag_o,
  output logic      pend_o
);

  logic flag_q;
  logic pend_q;

  ////////////////////////////////////////////////////////////////////////////
  // Level flags follow the source; an event is a change of state.
  // Sticky flags latch a pulse and drop only on a read, set winning.
  wire  level_changed = (level_i != flag_q) | retrig_i;
  wire  changed       = STICKY ? set_i : level_changed;
  wire  sticky_next   = set_i | (flag_q & ~clear_i);
  wire  flag_d        = STICKY ? sticky_next : level_i;
  // Pending event survives until read; a new change beats the clear
  wire  pend_d        = changed | (pend_q & ~clear_i);

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      flag_q <= 1'b0;
      pend_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
      pend_q <= pend_d;
    end
  end

  assign flag_o = flag_q;
  assign pend_o = pend_q;

endmodule

// File: rtl/spdif_rx_error_flags.sv
// Receiver fault flags, their enable mask and the summary interrupt bit.
// Assumes the receiver datapath runs on sys_clk_i; lock and stream-absent
// come from the clock recovery and are treated as asynchronous levels.
// The serial control port slave drives the simple register strobes.

module spdif_rx_error_flags
  import spdif_rx_flags_pkg::*;
(
  // Clock and reset
  input  wire logic                       sys_clk_i,
  input  wire logic                       rst_i,
  // Receiver status on sys_clk_i
  input  wire logic                       rx_validity_i,
  input  wire logic                       rx_emphasis_i,
  input  wire logic                       rx_nonaudio_i,
  input  wire logic [NONAUDIO_TYPE_W-1:0] rx_nonaudio_type_i,
  input  wire logic                       rx_preamble_nonaudio_i,
  input  wire logic                       rx_check_fail_i,
  input  wire logic                       rx_coding_error_i,
  // Asynchronous receiver levels
  input  wire logic                       input_absent_i,
  input  wire logic                       pll_lock_i,
  // Register port from the control interface
  input  wire logic [6:0]                 reg_addr_i,
  input  wire logic                       reg_wr_i,
  input  wire logic                       reg_rd_i,
  input  wire logic [7:0]                 reg_wdata_i,
  output logic      [7:0]                 reg_rdata_o,
  output logic                            reg_rvalid_o,
  // Flag view and interrupt request
  output logic      [7:0]                 receiver_fault_flags_o,
  output logic                            receiver_fault_summary_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [1:0]                 async_sync;
  logic                       input_absent_flag;
  logic                       lock_sync;
  logic [NONAUDIO_TYPE_W-1:0] type_q;
  logic [7:0]                 enable_q;
  logic [7:0]                 rdata_q;
  logic                       rvalid_q;
  logic                       summary_q;
  logic [7:0]                 flags_view_q;
  logic [7:0]                 flag_bits;
  logic [7:0]                 pend_bits;
  logic [7:0]                 level_vec;
  logic [7:0]                 set_vec;
  logic [7:0]                 retrig_vec;

  ////////////////////////////////////////////////////////////////////////////
  // Synchronise the levels that come from outside the clock domain

  level_sync #(
    .WIDTH (2)
  ) u_sync (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .async_i   ({input_absent_i, pll_lock_i}),
    .sync_o    (async_sync)
  );

  assign input_absent_flag = async_sync[1];
  assign lock_sync         = async_sync[0];

  ////////////////////////////////////////////////////////////////////////////
  // Nonaudio type tracking; a new code while nonaudio retriggers the event

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      type_q <= TYPE_RESET;
    end else begin
      type_q <= rx_nonaudio_type_i;
    end
  end

  wire type_changed = rx_nonaudio_i & (rx_nonaudio_type_i != type_q);

  ////////////////////////////////////////////////////////////////////////////
  // Register decode

  wire sel_flags   = (reg_addr_i == FAULT_FLAGS_ADDR);
  wire sel_enable  = (reg_addr_i == FAULT_ENABLE_ADDR);
  wire sel_status  = (reg_addr_i == IRQ_STATUS_ADDR);
  wire flags_read  = reg_rd_i & sel_flags;
  wire status_read = reg_rd_i & sel_status;
  // Writes to the flag register are dropped on purpose
  wire enable_wr   = reg_wr_i & sel_enable;

  ////////////////////////////////////////////////////////////////////////////
  // Flag source vectors; unused lanes are tied low

  always_comb begin
    level_vec = '0;
    set_vec   = '0;
    retrig_vec = '0;
    level_vec[VALID_BIT]      = rx_validity_i;
    level_vec[EMPHASIS_BIT]   = rx_emphasis_i;
    level_vec[NONAUDIO_BIT]   = rx_nonaudio_i;
    retrig_vec[NONAUDIO_BIT]  = type_changed;
    level_vec[PREAMBLE_BIT]   = rx_preamble_nonaudio_i;
    set_vec[CHECK_FAIL_BIT]   = rx_check_fail_i;
    level_vec[ABSENT_BIT]     = input_absent_flag;
    set_vec[CODING_BIT]       = rx_coding_error_i;
    level_vec[LOCK_BIT]       = lock_sync;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One cell per flag; the sticky map picks latch or change behaviour

  for (genvar i = 0; i < FLAG_COUNT; i++) begin : g_flag
    fault_flag_cell #(
      .STICKY (STICKY_MAP[i])
    ) u_cell (
      .sys_clk_i (sys_clk_i),
      .rst_i     (rst_i),
      .level_i   (level_vec[i]),
      .set_i     (set_vec[i]),
      .retrig_i  (retrig_vec[i]),
      .clear_i   (flags_read),
      .flag_o    (flag_bits[i]),
      .pend_o    (pend_bits[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Enable mask

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      enable_q <= ENABLE_RESET;
    end else if (enable_wr) begin
      enable_q <= reg_wdata_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Summary bit. An event that is masked stays pending, so enabling its
  // mask later still raises the summary unless the flags were read first.

  wire [7:0] gated_events = pend_bits & enable_q;
  wire       any_event    = |gated_events;
  // Set beats the clear of a status read in the same cycle
  wire       summary_d    = any_event | (summary_q & ~status_read);

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      summary_q <= SUMMARY_RESET;
    end else begin
      summary_q <= summary_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data. The flag value is captured before a read clears it, so a
  // sticky error seen in this read is never lost between reads.

  wire [7:0] status_word = {7'h00, summary_q};
  wire [7:0] read_mux    = sel_flags  ? flag_bits :
                           sel_enable ? enable_q  :
                           sel_status ? status_word :
                                        RDATA_RESET;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rdata_q  <= RDATA_RESET;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= reg_rd_i;
      if (reg_rd_i) begin
        rdata_q <= read_mux;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered flag view for the rest of the chip

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      flags_view_q <= FLAGS_RESET;
    end else begin
      flags_view_q <= flag_bits;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, each straight from a flip-flop

  assign reg_rdata_o              = rdata_q;
  assign reg_rvalid_o             = rvalid_q;
  assign receiver_fault_flags_o   = flags_view_q;
  assign receiver_fault_summary_o = summary_q;

endmodule

// File: dv/host_model.sv
// Host on the register port: simple read and write strobe cycles.
// Assumes the flag block answers a read with a one-cycle rvalid pulse.
module host_model (
  // Clock
  input  wire logic       sys_clk_i,
  // Register answer
  input  wire logic [7:0] reg_rdata_i,
  input  wire logic       reg_rvalid_i,
  // Register request
  output logic      [6:0] reg_addr_o,
  output logic            reg_wr_o,
  output logic            reg_rd_o,
  output logic      [7:0] reg_wdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle port from time zero
  initial begin
    reg_addr_o = 7'h00;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_wdata_o = 8'h00;
  end
  ////////////////////////////////////////////////////////////////////////////
  // One-cycle write strobe, changed only at falling edges
  task automatic wr_reg(input logic [6:0] a, input logic [7:0] d);
    @(negedge sys_clk_i);
    reg_addr_o = a;
    reg_wdata_o = d;
    reg_wr_o = 1'b1;
    @(negedge sys_clk_i);
    reg_wr_o = 1'b0;
    reg_wdata_o = ~d; // Stale data must not count
  endtask
  // Read strobe, then a bounded wait for the answer pulse
  task automatic rd_reg(input logic [6:0] a, output logic [7:0] d);
    int n;
    @(negedge sys_clk_i);
    reg_addr_o = a;
    reg_rd_o = 1'b1;
    @(negedge sys_clk_i);
    reg_rd_o = 1'b0;
    for (n = 0; n < 4 && reg_rvalid_i !== 1'b1; n++) begin
      @(negedge sys_clk_i);
    end
    d = (reg_rvalid_i === 1'b1) ? reg_rdata_i : 8'hXX;
  endtask
endmodule

// File: dv/spdif_rx_error_flags_assertions.sv
// Timing checks on the flag block ports.
// Assumes one clock domain and a synchronous active-high reset.
module spdif_rx_error_flags_checker
  import spdif_rx_flags_pkg::*;
(
  input wire logic       sys_clk_i, rst_i, rx_validity_i, reg_wr_i, reg_rd_i,
  input wire logic       rx_coding_error_i,
  input wire logic [6:0] reg_addr_i,
  input wire logic [7:0] reg_rdata_o, receiver_fault_flags_o,
  input wire logic       reg_rvalid_o, receiver_fault_summary_o
);
  // Decoded reads of the flag and status registers and of unmapped addresses
  wire logic rd_flags = reg_rd_i && reg_addr_i == FAULT_FLAGS_ADDR;
  wire logic rd_stat = reg_rd_i && reg_addr_i == IRQ_STATUS_ADDR;
  wire logic rd_other = reg_rd_i && !rd_flags && !rd_stat
                        && reg_addr_i != FAULT_ENABLE_ADDR;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////////////////
  a_rvalid_after_read: assert property (reg_rd_i |=> reg_rvalid_o)
    else $error("read not answered next cycle");
  a_flags_readback: assert property (rd_flags |=>
    reg_rdata_o == receiver_fault_flags_o) else $error("flag read wrong");
  a_status_readback: assert property (rd_stat |=> reg_rdata_o ==
    {7'h00, $past(receiver_fault_summary_o)}) else $error("status wrong");
  a_unmapped_zero: assert property (rd_other |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  a_coding_sets: assert property (rx_coding_error_i |-> ##2
    receiver_fault_flags_o[CODING_BIT]) else $error("coding flag missed");
  a_sticky_by_read: assert property (($fell(receiver_fault_flags_o[1]) ||
    $fell(receiver_fault_flags_o[3])) && !$past(rst_i, 1) &&
    !$past(rst_i, 2) |-> $past(rd_flags, 2)) else $error("sticky lost");
  a_validity_follow: assert property (receiver_fault_flags_o[VALID_BIT] ==
    ($past(rx_validity_i, 2) && !$past(rst_i, 1) && !$past(rst_i, 2)))
    else $error("validity flag wrong");
  a_summary_by_read: assert property ($fell(receiver_fault_summary_o)
    |-> $past(rd_stat)) else $error("summary cleared without read");
endmodule
bind spdif_rx_error_flags spdif_rx_error_flags_checker u_chk (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .rx_validity_i(rx_validity_i),
  .rx_coding_error_i(rx_coding_error_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
  .reg_rdata_o(reg_rdata_o), .receiver_fault_flags_o(receiver_fault_flags_o),
  .reg_rvalid_o(reg_rvalid_o),
  .receiver_fault_summary_o(receiver_fault_summary_o));

// File: dv/testbench.sv
// Self-checking bench for the receiver fault flag block.
// Assumes host_model drives the register port; levels change at falling edge.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import spdif_rx_flags_pkg::*;
  typedef struct packed { logic [7:0] lv; logic [7:0] exp; } row_type;
  logic clk, rst, v, e, na, pn, cf, ce, ab, lk, wr, rd, rvalid, summ;
  logic [3:0] ntype;
  logic [6:0] addr;
  logic [7:0] wdata, rdata, flags, d;
  int failures = 0;
  int num_checks = 0;
  row_type rows [7] = '{'{8'h00, 8'h00}, '{8'h80, 8'h80}, '{8'h40, 8'h40},
    '{8'h20, 8'h20}, '{8'h10, 8'h10}, '{8'h04, 8'h04}, '{8'h01, 8'h01}};
  ////////////////////////////////////////////////////////////////////////////
  spdif_rx_error_flags DUT (.sys_clk_i(clk), .rst_i(rst),
    .rx_validity_i(v), .rx_emphasis_i(e), .rx_nonaudio_i(na),
    .rx_nonaudio_type_i(ntype), .rx_preamble_nonaudio_i(pn),
    .rx_check_fail_i(cf), .rx_coding_error_i(ce), .input_absent_i(ab),
    .pll_lock_i(lk), .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
    .receiver_fault_flags_o(flags), .receiver_fault_summary_o(summ));
  host_model host (.sys_clk_i(clk), .reg_rdata_i(rdata),
    .reg_rvalid_i(rvalid), .reg_addr_o(addr), .reg_wr_o(wr),
    .reg_rd_o(rd), .reg_wdata_o(wdata));
  // 25 MHz clock; watchdog well beyond the expected run
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    #400000;
    failures++;
    complete_run();
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Level flags in register bit order; lock and absent need the sync delay
  task automatic levels(input logic [7:0] lv);
    @(negedge clk);
    {v, e, na, pn} = lv[7:4];
    ab = lv[ABSENT_BIT];
    lk = lv[LOCK_BIT];
    repeat (5) @(negedge clk);
  endtask
  task automatic clear_events();
    host.rd_reg(FAULT_FLAGS_ADDR, d);
    host.rd_reg(IRQ_STATUS_ADDR, d);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence: reset, table of level flags, then event cases
  initial begin
    {v, e, na, pn, cf, ce, ab, lk} = 8'h00;
    ntype = 4'h0;
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    host.rd_reg(FAULT_ENABLE_ADDR, d); check(d, ENABLE_RESET);
    host.rd_reg(IRQ_STATUS_ADDR, d); check(d, 8'h00);
    foreach (rows[i]) begin
      levels(rows[i].lv);
      host.rd_reg(FAULT_FLAGS_ADDR, d); check(d, rows[i].exp);
      check(flags, rows[i].exp);
    end
    levels(8'h00);
    host.wr_reg(FAULT_ENABLE_ADDR, 8'hA5);
    host.wr_reg(FAULT_FLAGS_ADDR, 8'hFF);
    host.rd_reg(FAULT_ENABLE_ADDR, d); check(d, 8'hA5);
    host.rd_reg(FAULT_FLAGS_ADDR, d); check(d, 8'h00);
    host.rd_reg(7'h30, d); check(d, 8'h00);
    // Enabled coding error: sticky until read, summary until status read
    host.wr_reg(FAULT_ENABLE_ADDR, 8'h02);
    clear_events();
    @(negedge clk) ce = 1'b1;
    @(negedge clk) ce = 1'b0;
    repeat (2) @(negedge clk);
    check({7'h00, summ}, 8'h01);
    repeat (6) @(negedge clk);
    host.rd_reg(FAULT_FLAGS_ADDR, d); check(d, 8'h02);
    host.rd_reg(FAULT_FLAGS_ADDR, d); check(d, 8'h00);
    host.rd_reg(IRQ_STATUS_ADDR, d); check(d, 8'h01);
    check({7'h00, summ}, 8'h00);
    // Masked check failure still latches but stays quiet
    host.wr_reg(FAULT_ENABLE_ADDR, 8'h00);
    @(negedge clk) cf = 1'b1;
    @(negedge clk) cf = 1'b0;
    repeat (3) @(negedge clk);
    check({7'h00, summ}, 8'h00);
    host.rd_reg(FAULT_FLAGS_ADDR, d); check(d, 8'h08);
    // Lock: one event per change of state only
    host.wr_reg(FAULT_ENABLE_ADDR, 8'h01);
    levels(8'h01);
    clear_events();
    repeat (4) @(negedge clk);
    check({7'h00, summ}, 8'h00);
    levels(8'h00);
    check({7'h00, summ}, 8'h01);
    // Nonaudio: new event on type change and on return to audio
    host.wr_reg(FAULT_ENABLE_ADDR, 8'h20);
    levels(8'h20);
    clear_events();
    repeat (3) @(negedge clk);
    check({7'h00, summ}, 8'h00);
    ntype = 4'h3;
    repeat (3) @(negedge clk);
    check({7'h00, summ}, 8'h01);
    clear_events();
    levels(8'h00);
    check({7'h00, summ}, 8'h01);
    // Reset in mid-run returns the mask to its reset value
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    host.rd_reg(FAULT_ENABLE_ADDR, d); check(d, ENABLE_RESET);
    complete_run();
  end
endmodule
